// *** shared/imsc_pkg.sv ***
package imsc_pkg;

	// Register byte addresses (one aligned word each)
	localparam logic [7:0] OFS_CTRL2  = 8'h00;
	localparam logic [7:0] OFS_BUF    = 8'h04;
	localparam logic [7:0] OFS_CFG    = 8'h08;
	localparam logic [7:0] OFS_STAT   = 8'h0c;

	// Control register two bit positions
	localparam int B_GCALL_IRQ  = 7;
	localparam int B_ACK_RCVD   = 6;
	localparam int B_ACK_VAL    = 5;
	localparam int B_ACK_REQ    = 4;
	localparam int B_RX_EN      = 3;
	localparam int B_STOP_REQ   = 2;
	localparam int B_RSTART_REQ = 1;
	localparam int B_START_REQ  = 0;

	// Config register bit positions
	localparam int B_MSTR  = 0;
	localparam int B_ENA   = 1;

	// Reset values
	localparam logic [7:0] RST_CTRL2 = 8'h00;
	localparam logic [7:0] RST_BUF   = 8'h00;
	localparam logic [7:0] RST_CFG   = 8'h00;

	// SCL half period in system clocks
	localparam logic [7:0] HALF_CYC  = 8'h04;

	// One-shot sequences the engine can run
	typedef enum logic [2:0] {
		IMSC_SEQ_NONE,
		IMSC_SEQ_START,
		IMSC_SEQ_RSTART,
		IMSC_SEQ_STOP,
		IMSC_SEQ_RECV,
		IMSC_SEQ_ACK
	} imsc_seq_t;

	// Open-drain pin as value and enable
	typedef struct packed {
		logic o;
		logic oe;
	} imsc_od_t;

endpackage

// *** core/imsc_seq_engine.sv ***
`timescale 1ns/1ps
module imsc_seq_engine (
	input  wire logic               i_mclk,
	input  wire logic               i_sys_rst,
	input  wire imsc_pkg::imsc_seq_t i_seq,
	input  wire logic               i_go,
	input  wire logic               i_ack_bit,
	input  wire logic               i_sda,
	output logic                    o_busy,
	output logic                    o_done,
	output logic [7:0]              o_rx_byte,
	output logic                    o_sda_low,
	output logic                    o_scl_low
);
	import imsc_pkg::*;

	imsc_seq_t  seq_q;
	logic [7:0] tick_q;
	logic [4:0] ph_q;
	logic [4:0] last;

	////////////////////////////////////////////////////////////////////////
	// Last phase index per sequence: each phase is one half SCL period
	always_comb begin
		case (seq_q)
			IMSC_SEQ_START:  last = 5'd1;
			IMSC_SEQ_RSTART: last = 5'd3;
			IMSC_SEQ_STOP:   last = 5'd2;
			IMSC_SEQ_RECV:   last = 5'd15;
			IMSC_SEQ_ACK:    last = 5'd1;
			default:         last = 5'd0;
		endcase
	end

	// Sequencer: busy from launch until last phase ends
	always_ff @(posedge i_mclk) begin
		o_done <= 1'b0;
		if (i_sys_rst) begin
			seq_q  <= IMSC_SEQ_NONE;
			tick_q <= 8'h00;
			ph_q   <= 5'd0;
			o_busy <= 1'b0;
		end else if (!o_busy) begin
			if (i_go) begin
				seq_q  <= i_seq;
				o_busy <= 1'b1;
				tick_q <= 8'h00;
				ph_q   <= 5'd0;
			end
		end else if (tick_q == HALF_CYC - 8'h01) begin
			tick_q <= 8'h00;
			if (ph_q == last) begin
				o_busy <= 1'b0;
				o_done <= 1'b1;
			end else begin
				ph_q <= ph_q + 5'd1;
			end
		end else begin
			tick_q <= tick_q + 8'h01;
		end
	end

	// Receive shift: sample SDA at the end of each high phase
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_rx_byte <= 8'h00;
		else if (o_busy && seq_q == IMSC_SEQ_RECV && ph_q[0]
			&& tick_q == HALF_CYC - 8'h01)
			o_rx_byte <= {o_rx_byte[6:0], i_sda};
	end

	// Pin pattern; SCL low on even phases of clocked sequences
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_sda_low <= 1'b0;
			o_scl_low <= 1'b0;
		end else if (!o_busy) begin
			o_sda_low <= o_sda_low;
			o_scl_low <= o_scl_low;
		end else begin
			case (seq_q)
				IMSC_SEQ_START: begin
					o_sda_low <= 1'b1;
					o_scl_low <= ph_q == 5'd1;
				end
				IMSC_SEQ_RSTART: begin
					o_sda_low <= ph_q >= 5'd2;
					o_scl_low <= ph_q == 5'd0 || ph_q == 5'd3;
				end
				IMSC_SEQ_STOP: begin
					o_sda_low <= ph_q != 5'd2;
					o_scl_low <= ph_q == 5'd0;
				end
				IMSC_SEQ_RECV: begin
					o_sda_low <= 1'b0;
					o_scl_low <= !ph_q[0];
				end
				IMSC_SEQ_ACK: begin
					o_sda_low <= !i_ack_bit;
					o_scl_low <= ph_q == 5'd0;
				end
				default: begin
					o_sda_low <= 1'b0;
					o_scl_low <= 1'b0;
				end
			endcase
		end
	end
endmodule

// *** core/imsc_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - In enabled master mode, receive enable starts reception; clear means receive idle.
// - Repeated start request launches the condition; hardware clears it when done.
// - Repeated start field reads zero when no repeated start pending.
// - Sequence requests written while busy are dropped, never queued.
// - Transfer buffer writes while busy are blocked, contents unchanged.
module imsc_ctrl (
	input  wire logic              i_mclk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [7:0]        i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic              i_sda,
	input  wire logic              i_scl,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output imsc_pkg::imsc_od_t     o_sda,
	output imsc_pkg::imsc_od_t     o_scl
);
	import imsc_pkg::*;

	logic [7:0] ctrl2_q;
	logic [7:0] buf_q;
	logic [1:0] cfg_q;
	logic       busy;
	logic       done;
	logic [7:0] rx_byte;
	logic       sda_low;
	logic       scl_low;
	logic       go;
	imsc_seq_t  seq;
	imsc_seq_t  act_q;
	logic       acc;
	logic       wr;
	logic       mapped;

	////////////////////////////////////////////////////////////////////////
	// APB decode; every access completes in its second access cycle, after one wait state
	assign acc    = i_psel && i_penable && o_pready;
	assign wr     = acc && i_pwrite;
	assign mapped = i_paddr == OFS_CTRL2 || i_paddr == OFS_BUF
		|| i_paddr == OFS_CFG || i_paddr == OFS_STAT;

	// Ready pulses one cycle into the access phase
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_pready <= 1'b0;
		else
			o_pready <= i_psel && i_penable && !o_pready;
	end

	// Read data and error flag registered with ready
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
			case (i_paddr)
				OFS_CTRL2: o_prdata <= {24'h00_0000, ctrl2_q};
				OFS_BUF:   o_prdata <= {24'h00_0000, buf_q};
				OFS_CFG:   o_prdata <= {30'h0000_0000, cfg_q};
				OFS_STAT:  o_prdata <= {31'h0000_0000, busy};
				default:   o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Config: enable and master mode
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			cfg_q <= RST_CFG[1:0];
		else if (wr && i_paddr == OFS_CFG)
			cfg_q <= i_pwdata[1:0];
	end

	// Request decode, lowest bit wins if several are written at once
	always_comb begin
		seq = IMSC_SEQ_NONE;
		go  = 1'b0;
		if (wr && i_paddr == OFS_CTRL2 && !busy && cfg_q[B_MSTR]
			&& cfg_q[B_ENA]) begin
			go = 1'b1;
			if (i_pwdata[B_START_REQ])
				seq = IMSC_SEQ_START;
			else if (i_pwdata[B_RSTART_REQ])
				seq = IMSC_SEQ_RSTART;
			else if (i_pwdata[B_STOP_REQ])
				seq = IMSC_SEQ_STOP;
			else if (i_pwdata[B_RX_EN])
				seq = IMSC_SEQ_RECV;
			else if (i_pwdata[B_ACK_REQ])
				seq = IMSC_SEQ_ACK;
			else
				go = 1'b0;
		end
	end

	// Remember which one-shot field belongs to the running sequence
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			act_q <= IMSC_SEQ_NONE;
		else if (go)
			act_q <= seq;
		else if (done)
			act_q <= IMSC_SEQ_NONE;
	end

	// Control two: one-shot fields set by software, cleared on completion.
	// Set bits outside the launched request are dropped, not queued.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ctrl2_q <= RST_CTRL2;
		end else begin
			if (wr && i_paddr == OFS_CTRL2) begin
				ctrl2_q[B_GCALL_IRQ] <= i_pwdata[B_GCALL_IRQ];
				ctrl2_q[B_ACK_VAL]   <= i_pwdata[B_ACK_VAL];
			end
			if (go) begin
				ctrl2_q[B_START_REQ]  <= seq == IMSC_SEQ_START;
				ctrl2_q[B_RSTART_REQ] <= seq == IMSC_SEQ_RSTART;
				ctrl2_q[B_STOP_REQ]   <= seq == IMSC_SEQ_STOP;
				ctrl2_q[B_RX_EN]      <= seq == IMSC_SEQ_RECV;
				ctrl2_q[B_ACK_REQ]    <= seq == IMSC_SEQ_ACK;
			end else if (done) begin
				ctrl2_q[B_START_REQ]  <= 1'b0;
				ctrl2_q[B_RSTART_REQ] <= 1'b0;
				ctrl2_q[B_STOP_REQ]   <= 1'b0;
				ctrl2_q[B_RX_EN]      <= 1'b0;
				ctrl2_q[B_ACK_REQ]    <= 1'b0;
			end
			// Ack sampled on SDA at the ninth clock is not modelled here
			ctrl2_q[B_ACK_RCVD] <= 1'b0;
		end
	end

	// Transfer buffer: blocked while busy, loaded by receive
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			buf_q <= RST_BUF;
		else if (done && act_q == IMSC_SEQ_RECV)
			buf_q <= rx_byte;
		else if (wr && i_paddr == OFS_BUF && !busy)
			buf_q <= i_pwdata[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	imsc_seq_engine u_eng (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_seq     (seq),
		.i_go      (go),
		.i_ack_bit (ctrl2_q[B_ACK_VAL]),
		.i_sda     (i_sda),
		.o_busy    (busy),
		.o_done    (done),
		.o_rx_byte (rx_byte),
		.o_sda_low (sda_low),
		.o_scl_low (scl_low)
	);

	// Open drain: drive low only, output value always zero
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_sda <= '0;
			o_scl <= '0;
		end else begin
			o_sda.o  <= 1'b0;
			o_sda.oe <= sda_low;
			o_scl.o  <= 1'b0;
			o_scl.oe <= scl_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_rs_req;
		wr && i_paddr == OFS_CTRL2 && i_pwdata[B_RSTART_REQ] && go
			&& seq == IMSC_SEQ_RSTART;
	endsequence

	// Launch of a stop sequence
	sequence s_stop_req;
		go && seq == IMSC_SEQ_STOP;
	endsequence

	// Launch of a receive sequence
	sequence s_rx_req;
		go && seq == IMSC_SEQ_RECV;
	endsequence

	// Buffer write that lands while the engine runs
	sequence s_buf_wr_busy;
		wr && i_paddr == OFS_BUF && busy;
	endsequence

	// Control write that lands while the engine runs
	sequence s_ctl_wr_busy;
		wr && i_paddr == OFS_CTRL2 && busy;
	endsequence

	// Repeated start field follows its sequence
	rstart_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		s_rs_req |=> ctrl2_q[B_RSTART_REQ] && busy)
		else $error("repeated start field not set");
	rstart_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl2_q[B_RSTART_REQ] && done && !go
		|=> !ctrl2_q[B_RSTART_REQ])
		else $error("repeated start field not cleared");
	// Field drops the cycle after done, so that cycle is excluded
	rstart_idle_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!busy && !done && !go |-> !ctrl2_q[B_RSTART_REQ])
		else $error("repeated start field set while idle");

	// Stop field set at launch, lines released at completion
	stop_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		s_stop_req |=> ctrl2_q[B_STOP_REQ] && busy)
		else $error("stop field not set");
	stop_release_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl2_q[B_STOP_REQ] && done |=> !o_sda.oe && !o_scl.oe)
		else $error("lines not released after stop");

	// Requests and buffer writes while busy leave no trace
	ctl_drop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		s_ctl_wr_busy |=> $stable(ctrl2_q[4:0]))
		else $error("request field changed while busy");
	buf_block_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		s_buf_wr_busy |=> $stable(buf_q))
		else $error("buffer written while busy");

	// Receive releases SDA and delivers its byte
	rx_pins_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$past(busy) && busy && act_q == IMSC_SEQ_RECV |-> !sda_low)
		else $error("data line driven during receive");
	rx_load_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		done && act_q == IMSC_SEQ_RECV |=> buf_q == $past(rx_byte))
		else $error("received byte not in buffer");

	// Bus answer shape, and ack field cleared on completion
	ready_pulse_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	err_ready_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_pslverr |-> o_pready)
		else $error("error flag without ready");
	ack_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl2_q[B_ACK_REQ] && done && !go |=> !ctrl2_q[B_ACK_REQ])
		else $error("ack field not cleared");

	busy_drop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		busy |-> !go)
		else $error("request accepted while busy");
	busy_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		busy && !done && act_q != IMSC_SEQ_RECV |=> $stable(buf_q))
		else $error("buffer changed while busy");
	rx_mode_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		s_rx_req |=> ctrl2_q[B_RX_EN] ##1 scl_low)
		else $error("receive not started");
	rx_idle_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!ctrl2_q[B_RX_EN] |-> act_q != IMSC_SEQ_RECV)
		else $error("receive running with field clear");
	// A new launch in the done cycle may legally restart the engine
	stop_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl2_q[B_STOP_REQ] && done && !go
		|=> !ctrl2_q[B_STOP_REQ] && !busy)
		else $error("stop field not cleared");
endmodule

// *** tb/imsc_bus_partner.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Far-side transmitter: shifts one byte onto SDA, MSB first
module imsc_bus_partner (
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_scl,
	input  wire logic       i_arm,
	input  wire logic [7:0] i_byte,
	output logic            o_sda_oe
);
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic       scl_q;
	logic       hi_q;
	// Advance on each SCL fall so data is steady while SCL is high.
	// MSB is shown from arming; only falls after a high phase shift.
	always_ff @(posedge i_mclk) begin
		scl_q <= i_scl;
		if (i_sys_rst) begin
			cnt_q <= 4'h0;
			sh_q  <= 8'h00;
			hi_q  <= 1'b0;
		end else if (i_arm) begin
			sh_q  <= i_byte;
			cnt_q <= 4'h8;
			hi_q  <= 1'b0;
		end else begin
			if (!scl_q && i_scl)
				hi_q <= 1'b1;
			if (scl_q && !i_scl && hi_q && cnt_q != 4'h0) begin
				sh_q  <= {sh_q[6:0], 1'b0};
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
	// Released line floats high through the pull-up
	assign o_sda_oe = (cnt_q != 4'h0) & ~sh_q[7];
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	import imsc_pkg::*;
	logic        clk, rst, psel, penable, pwrite, arm, p_oe;
	logic [7:0]  paddr, pbyte;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, sda, scl;
	imsc_od_t    dsda, dscl;
	int          fail_count, checks;
	// Open-drain wires with pull-ups
	assign sda = ~(dsda.oe | p_oe);
	assign scl = ~dscl.oe;
	imsc_ctrl u_dut (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_sda(sda), .i_scl(scl), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_sda(dsda), .o_scl(dscl));
	imsc_bus_partner u_far (.i_mclk(clk), .i_sys_rst(rst), .i_scl(scl),
		.i_arm(arm), .i_byte(pbyte), .o_sda_oe(p_oe));
	////////////////////////////////////////////////////////////////
	// APB cycle; an edge first so no signal is set twice in a step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
		r = prdata; e = pslverr;
		if (n >= 50) begin fail_count++; $display("[ERR] %0t no pready", $time); end
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// Poll control two until every request bit is clear, bounded
	task automatic wait_idle();
		logic e; int n;
		n = 0;
		do begin apb(0, OFS_CTRL2, 0, rd, e); n++; end
		while (rd[4:0] !== 5'h00 && n < 100);
	endtask
	task automatic t_reset();
		logic e;
		apb(0, OFS_CTRL2, 0, rd, e); `CHK(rd, 32'h00000000)
		apb(0, OFS_BUF, 0, rd, e); `CHK(rd, 32'h00000000)
		apb(0, OFS_STAT, 0, rd, e); `CHK(rd, 32'h00000000)
		apb(0, 8'h3c, 0, rd, e); `CHK(e, 1'b1)
		`CHK(rd, 32'h00000000)
		apb(1, OFS_CFG, 32'h3, rd, e);
		apb(0, OFS_CFG, 0, rd, e); `CHK(rd, 32'h00000003)
		apb(1, OFS_BUF, 32'h3c, rd, e);
		apb(0, OFS_BUF, 0, rd, e); `CHK(rd, 32'h0000003c)
		$display("test reset done");
	endtask
	// Repeated start with refused requests and buffer write meanwhile
	task automatic t_rstart();
		logic e;
		apb(1, OFS_CTRL2, 32'h02, rd, e);
		apb(0, OFS_STAT, 0, rd, e); `CHK(rd[0], 1'b1)
		apb(1, OFS_BUF, 32'h77, rd, e);
		apb(1, OFS_CTRL2, 32'h06, rd, e);
		wait_idle(); `CHK(rd[1], 1'b0)
		`CHK(rd[2], 1'b0)
		apb(0, OFS_STAT, 0, rd, e); `CHK(rd[0], 1'b0)
		apb(0, OFS_BUF, 0, rd, e); `CHK(rd, 32'h0000003c)
		$display("test repeated start done");
	endtask
	// Start, then an acknowledge with the value bit clear
	task automatic t_start_ack();
		logic e;
		apb(1, OFS_CTRL2, 32'h01, rd, e);
		wait_idle(); `CHK(rd[0], 1'b0)
		`CHK({sda, scl}, 2'b00)
		apb(1, OFS_CTRL2, 32'h10, rd, e);
		apb(0, OFS_STAT, 0, rd, e); `CHK(rd[0], 1'b1)
		wait_idle(); `CHK(rd[4], 1'b0)
		$display("test start and ack done");
	endtask
	// Stop must finish with both lines released
	task automatic t_stop();
		logic e;
		apb(1, OFS_CTRL2, 32'h04, rd, e);
		wait_idle(); `CHK(rd[2], 1'b0)
		`CHK({sda, scl}, 2'b11)
		$display("test stop done");
	endtask
	// Receive one byte from the far side into the buffer
	task automatic t_recv();
		logic e;
		@(posedge clk);
		arm <= 1'b1; pbyte <= 8'ha5;
		@(posedge clk);
		arm <= 1'b0;
		apb(1, OFS_CTRL2, 32'h08, rd, e);
		wait_idle(); `CHK(rd[3], 1'b0)
		apb(0, OFS_BUF, 0, rd, e); `CHK(rd, 32'h000000a5)
		$display("test receive done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// Watchdog: the tests need a few thousand cycles at most
	initial begin
		#160000;
		fail_count++;
		wrap_up();
	end
	initial begin
		rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		arm = 0; pbyte = 0; fail_count = 0; checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rstart();
		t_start_ack();
		t_stop();
		t_recv();
		wrap_up();
	end
endmodule
